/* File: core/ubrg_params.svh */
// Offsets, field positions, reset values and counts of the baud generator.
// Included by its bare name; holds definitions only.
`ifndef UBRG_PARAMS_SVH
`define UBRG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define UBRG_OFF_MODE 8'h00
`define UBRG_OFF_CKSEL 8'h04
`define UBRG_OFF_DIV 8'h08
`define UBRG_OFF_TXBUF 8'h0C
`define UBRG_OFF_STATUS 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UBRG_MODE_POWER_BIT 7
`define UBRG_MODE_TXE_BIT 6
`define UBRG_MODE_RXE_BIT 5
`define UBRG_CKSEL_MSB 3
`define UBRG_DIV_MSB 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UBRG_RST_MODE 8'h00
`define UBRG_RST_CKSEL 4'h0
`define UBRG_RST_DIV 8'hFF
`define UBRG_RST_TXBUF 8'h00

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define UBRG_PRESC_W 10
`define UBRG_MAX_DIV_CODE 4'hA
`define UBRG_TIMER_CODE 4'hB
`define UBRG_SYNC_STAGES 3

`endif

/* File: core/ubrg_pkg.sv */
// Types shared by the baud generator and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
package ubrg_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ubrg_bus_req_t;

  typedef struct packed {
    logic uart_power_on;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic [4:0] spare;
  } ubrg_mode_t;

  typedef enum logic [2:0] {
    UBRG_SEL_NONE = 3'b001,
    UBRG_SEL_MODE = 3'b010,
    UBRG_SEL_OTHER = 3'b100
  } ubrg_dummy_t;

  typedef enum logic [1:0] {
    UBRG_RX_IDLE = 2'b01,
    UBRG_RX_RUN = 2'b10
  } ubrg_rx_state_t;

  typedef enum logic [2:0] {
    UBRG_REG_MODE,
    UBRG_REG_CKSEL,
    UBRG_REG_DIV,
    UBRG_REG_TXBUF,
    UBRG_REG_STATUS,
    UBRG_REG_NONE
  } ubrg_reg_t;

endpackage

/* File: core/ubrg_top.sv */
// Baud rate generator of an asynchronous serial unit: base clock
// selection, transmit and receive divider counters, register port.
// Assumes the shifters sit outside on the same clock and report frame
// events as one-cycle pulses; the timer output may come from anywhere.
//
// Contract
// - Base clock from selected source reaches the unit only while powered.
// - With power off the base clock output stays low.
// - Transmit counter stopped at zero unless power and transmit enable.
// - Transmit counter counts base clocks once power and enable are set.
// - First transmit buffer write clears the transmit counter to zero.
// - Back-to-back frames clear the transmit counter at each frame end.
// - With nothing pending after a frame the transmit counter runs on.
// - Receive counter stopped at zero unless power and receive enable.
// - Receive counter starts only when a start bit is detected.
// - Receive counter halts after one frame until next start bit.
// - Eight-bit divisor sets counter ratio, valid from 4 to 255.
// - Bit rate equals base clock over the divisor.
// - Select codes 0..10 divide by 2^n, code 11 picks timer output.
// - Two independent eight-bit counters, one transmit, one receive.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "ubrg_params.svh"

module ubrg_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic TIMER_OUT_I,
  input wire logic TX_BUSY_I,
  input wire logic TX_FRAME_DONE_I,
  input wire logic TX_NEXT_PENDING_I,
  input wire logic RX_START_I,
  input wire logic RX_FRAME_DONE_I,
  output logic BASE_CLK_O,
  output logic TX_BAUD_TICK_O,
  output logic RX_BAUD_TICK_O,
  output logic TX_LOAD_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_RUN_O,
  output logic RX_RUN_O
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function automatic ubrg_pkg::ubrg_reg_t reg_decode(
    input logic [7:0] addr
  );
    ubrg_pkg::ubrg_reg_t r;
    unique case (addr)
      `UBRG_OFF_MODE: r = ubrg_pkg::UBRG_REG_MODE;
      `UBRG_OFF_CKSEL: r = ubrg_pkg::UBRG_REG_CKSEL;
      `UBRG_OFF_DIV: r = ubrg_pkg::UBRG_REG_DIV;
      `UBRG_OFF_TXBUF: r = ubrg_pkg::UBRG_REG_TXBUF;
      `UBRG_OFF_STATUS: r = ubrg_pkg::UBRG_REG_STATUS;
      default: r = ubrg_pkg::UBRG_REG_NONE;
    endcase
    return r;
  endfunction

  ubrg_pkg::ubrg_bus_req_t req;
  ubrg_pkg::ubrg_reg_t wr_sel;
  ubrg_pkg::ubrg_reg_t rd_sel;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign wr_sel = reg_decode(req.addr);
  assign rd_sel = reg_decode(req.addr);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  ubrg_pkg::ubrg_mode_t mode_q;
  logic [3:0] cksel_q;
  logic [7:0] div_q;
  logic [7:0] txbuf_q;
  logic tx_load_q;
  logic txbuf_wr;

  assign txbuf_wr = req.wr && (wr_sel == ubrg_pkg::UBRG_REG_TXBUF);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mode_q <= `UBRG_RST_MODE;
    end else if (req.wr && wr_sel == ubrg_pkg::UBRG_REG_MODE) begin
      mode_q <= req.wdata;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cksel_q <= `UBRG_RST_CKSEL;
    end else if (req.wr && wr_sel == ubrg_pkg::UBRG_REG_CKSEL) begin
      cksel_q <= req.wdata[`UBRG_CKSEL_MSB:0];
    end
  end

  // Divisor below 4 is left to software to avoid
  // software limit
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      div_q <= `UBRG_RST_DIV;
    end else if (req.wr && wr_sel == ubrg_pkg::UBRG_REG_DIV) begin
      div_q <= req.wdata[`UBRG_DIV_MSB:0];
    end
  end

  // Buffer write hands the byte to the transmitter
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      txbuf_q <= `UBRG_RST_TXBUF;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= txbuf_wr;
      if (txbuf_wr) begin
        txbuf_q <= req.wdata;
      end
    end
  end

  logic power_on;
  logic tx_on;
  logic rx_on;

  assign power_on = mode_q.uart_power_on;
  assign tx_on = mode_q.uart_power_on && mode_q.tx_enable_bit;
  assign rx_on = mode_q.uart_power_on && mode_q.rx_enable_bit;

  // --------------------------------------------------------------------
  // Timer output synchroniser
  // --------------------------------------------------------------------
  // Stage 0 feeds only stage 1; stages 1 and 2 must agree to count
  logic [`UBRG_SYNC_STAGES-1:0] tmr_sync_q;
  logic tmr_level_q;
  logic tmr_rise;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tmr_sync_q <= '0;
    end else begin
      tmr_sync_q <= {tmr_sync_q[1:0], TIMER_OUT_I};
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tmr_level_q <= 1'b0;
    end else if (tmr_sync_q[1] == tmr_sync_q[2]) begin
      tmr_level_q <= tmr_sync_q[2];
    end
  end

  assign tmr_rise = (tmr_sync_q[1] == tmr_sync_q[2]) && tmr_sync_q[2] &&
                    !tmr_level_q;

  // --------------------------------------------------------------------
  // Prescaler and base clock select
  // --------------------------------------------------------------------
  // Base clock is carried as a one-cycle tick per base period
  logic [`UBRG_PRESC_W-1:0] presc_q;
  logic [`UBRG_PRESC_W:0] div_tick;
  logic base_tick;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !power_on) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  assign div_tick[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 1; gi <= `UBRG_PRESC_W; gi = gi + 1) begin : g_tick
      assign div_tick[gi] = &presc_q[gi-1:0];
    end
  endgenerate

  always_comb begin
    if (cksel_q <= `UBRG_MAX_DIV_CODE) begin
      base_tick = div_tick[cksel_q];
    end else if (cksel_q == `UBRG_TIMER_CODE) begin
      base_tick = tmr_rise;
    end else begin
      base_tick = 1'b0;
    end
  end

  logic base_q;
  logic base_on;

  assign base_on = power_on && base_tick;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      base_q <= 1'b0;
    end else begin
      base_q <= base_on;
    end
  end

  // --------------------------------------------------------------------
  // Transmit divider counter
  // --------------------------------------------------------------------
  // own counter
  logic [7:0] tx_cnt_q;
  logic tx_tick_q;
  logic tx_clear;
  logic tx_wrap;

  assign tx_clear = (txbuf_wr && !TX_BUSY_I) ||
                    (TX_FRAME_DONE_I && TX_NEXT_PENDING_I);
  assign tx_wrap = base_on && (tx_cnt_q >= div_q - 8'h01);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !tx_on || tx_clear) begin
      tx_cnt_q <= 8'h00;
    end else if (tx_wrap) begin
      tx_cnt_q <= 8'h00;
    end else if (base_on) begin
      tx_cnt_q <= tx_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tx_tick_q <= 1'b0;
    end else begin
      tx_tick_q <= tx_on && !tx_clear && tx_wrap;
    end
  end

  // --------------------------------------------------------------------
  // Receive divider counter
  // --------------------------------------------------------------------
  ubrg_pkg::ubrg_rx_state_t rx_state_q;
  logic [7:0] rx_cnt_q;
  logic rx_tick_q;
  logic rx_wrap;
  logic rx_running;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !rx_on) begin
      rx_state_q <= ubrg_pkg::UBRG_RX_IDLE;
    end else begin
      unique case (rx_state_q)
        ubrg_pkg::UBRG_RX_IDLE: begin
          if (RX_START_I) begin
            rx_state_q <= ubrg_pkg::UBRG_RX_RUN;
          end
        end
        ubrg_pkg::UBRG_RX_RUN: begin
          if (RX_FRAME_DONE_I) begin
            rx_state_q <= ubrg_pkg::UBRG_RX_IDLE;
          end
        end
        default: rx_state_q <= ubrg_pkg::UBRG_RX_IDLE;
      endcase
    end
  end

  assign rx_running = (rx_state_q == ubrg_pkg::UBRG_RX_RUN);
  assign rx_wrap = base_on && (rx_cnt_q >= div_q - 8'h01);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !rx_on || !rx_running) begin
      rx_cnt_q <= 8'h00;
    end else if (rx_wrap) begin
      rx_cnt_q <= 8'h00;
    end else if (base_on) begin
      rx_cnt_q <= rx_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rx_tick_q <= 1'b0;
    end else begin
      rx_tick_q <= rx_on && rx_running && rx_wrap;
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] status;

  assign status = {power_on, tx_on, rx_on, rx_running,
                   tmr_level_q, base_q, 2'h0};

  // Unmapped reads and unused mode bits return zero
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      unique case (rd_sel)
        ubrg_pkg::UBRG_REG_MODE: rdata_q <= {mode_q[7:5], 5'h00};
        ubrg_pkg::UBRG_REG_CKSEL: rdata_q <= {4'h0, cksel_q};
        ubrg_pkg::UBRG_REG_DIV: rdata_q <= div_q;
        ubrg_pkg::UBRG_REG_TXBUF: rdata_q <= txbuf_q;
        ubrg_pkg::UBRG_REG_STATUS: rdata_q <= status;
        ubrg_pkg::UBRG_REG_NONE: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign RDATA_O = rdata_q;
  assign BASE_CLK_O = base_q;
  assign TX_BAUD_TICK_O = tx_tick_q;
  assign RX_BAUD_TICK_O = rx_tick_q;
  assign TX_LOAD_O = tx_load_q;
  assign TX_DATA_O = txbuf_q;
  assign TX_RUN_O = tx_on;
  assign RX_RUN_O = rx_running;

endmodule

/* File: dv/ubrg_top_asserts.sv */
// Concurrent checks on the baud generator top ports.
// Bound to every ubrg_top; one clock, synchronous active-high reset.
`timescale 1ns/100ps
`include "ubrg_params.svh"

module ubrg_asserts (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic TX_BUSY_I,
  input wire logic TX_FRAME_DONE_I,
  input wire logic TX_NEXT_PENDING_I,
  input wire logic RX_START_I,
  input wire logic RX_FRAME_DONE_I,
  input wire logic BASE_CLK_O,
  input wire logic TX_BAUD_TICK_O,
  input wire logic RX_BAUD_TICK_O,
  input wire logic TX_LOAD_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_RUN_O,
  input wire logic RX_RUN_O
);
  // ------
  // Power bit mirror
  // ------
  logic pwr_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      pwr_q <= 1'b0;
    end else if (WR_I && ADDR_I == `UBRG_OFF_MODE) begin
      pwr_q <= WDATA_I[`UBRG_MODE_POWER_BIT];
    end
  end

  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  sequence buf_wr;
    WR_I && ADDR_I == `UBRG_OFF_TXBUF;
  endsequence
  // Counter restarts from zero, so k of at least 4 leaves a gap
  sequence tx_quiet;
    !TX_BAUD_TICK_O [*3];
  endsequence

  chk_base_gated: assert property (
    !pwr_q |=> !BASE_CLK_O) else $error("base clock while powered off");
  chk_tx_halted: assert property (
    !TX_RUN_O [*2] |-> !TX_BAUD_TICK_O) else $error("tx tick while off");
  chk_rx_halted: assert property (
    !RX_RUN_O [*2] |-> !RX_BAUD_TICK_O) else $error("rx tick while idle");
  chk_rx_start: assert property (
    $rose(RX_RUN_O) |-> $past(RX_START_I)) else $error("rx run no start");
  chk_rx_stop: assert property (
    RX_FRAME_DONE_I && RX_RUN_O && !RX_START_I |=> !RX_RUN_O)
    else $error("rx counter kept running");
  chk_tx_load: assert property (
    buf_wr |=> TX_LOAD_O && TX_DATA_O == $past(WDATA_I))
    else $error("buffer load wrong");
  chk_tx_first: assert property (
    buf_wr ##0 (!TX_BUSY_I && TX_RUN_O) |=> ##1 tx_quiet)
    else $error("tx counter not cleared on write");
  chk_tx_frame: assert property (
    TX_FRAME_DONE_I && TX_NEXT_PENDING_I && TX_RUN_O |=> ##1 tx_quiet)
    else $error("tx counter not cleared at frame");
endmodule

bind ubrg_top ubrg_asserts i_ubrg_asserts (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .TX_BUSY_I(TX_BUSY_I),
  .TX_FRAME_DONE_I(TX_FRAME_DONE_I), .RX_START_I(RX_START_I),
  .TX_NEXT_PENDING_I(TX_NEXT_PENDING_I), .RX_RUN_O(RX_RUN_O),
  .RX_FRAME_DONE_I(RX_FRAME_DONE_I), .BASE_CLK_O(BASE_CLK_O),
  .TX_BAUD_TICK_O(TX_BAUD_TICK_O), .RX_BAUD_TICK_O(RX_BAUD_TICK_O),
  .TX_LOAD_O(TX_LOAD_O), .TX_DATA_O(TX_DATA_O), .TX_RUN_O(TX_RUN_O)
);

/* File: dv/ubrg_top_bench.sv */
// Self-checking bench for the baud generator top.
// Drives every port itself; the checker is bound in separately.
`timescale 1ns/100ps
`include "ubrg_params.svh"

module ubrg_top_bench;
  logic clk, rst, wr, rd, tmr, busy, pend, rd_q;
  logic bclk, ttick, rtick, tload, trun, rrun;
  logic [2:0] ev;
  logic [7:0] addr, wd, rdat, tdat, d;
  logic [7:0] exp_q[$];
  int fails, cmp_count, n, k;

  ubrg_top i_ubrg_top (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .TIMER_OUT_I(tmr),
    .TX_BUSY_I(busy), .TX_FRAME_DONE_I(ev[0]), .RX_START_I(ev[1]),
    .TX_NEXT_PENDING_I(pend), .RX_FRAME_DONE_I(ev[2]),
    .BASE_CLK_O(bclk), .TX_BAUD_TICK_O(ttick), .RX_BAUD_TICK_O(rtick),
    .TX_LOAD_O(tload), .TX_DATA_O(tdat), .TX_RUN_O(trun),
    .RX_RUN_O(rrun)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------
  // Shared tasks
  // ------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(v);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic [2:0] v, input logic p);
    @(posedge clk);
    ev <= v;
    pend <= p;
    @(posedge clk);
    ev <= 3'b000;
  endtask

  function automatic logic sig(input int s);
    return s == 0 ? bclk : (s == 1 ? ttick : rtick);
  endfunction

  // Cycles until the chosen output pulses, bounded
  task automatic gap(input int s, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (sig(s) !== 1'b1 && c < 5000);
    if (c >= 5000) begin
      fails++;
      final_report();
    end
  endtask

  task automatic quiet(input int s, input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
      chk(sig(s), 0);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      chk(rdat, exp_q.pop_front());
    end
    rd_q <= rd;
  end

  // ------
  // Main sequence
  // ------
  initial begin
    {rst, wr, rd, tmr, busy, pend, ev, addr, wd} = '0;
    rst = 1'b1;
    void'($urandom(25509));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus_rd(`UBRG_OFF_DIV, 8'hFF);
    bus_rd(`UBRG_OFF_MODE, 8'h00);
    bus_rd(8'h14, 8'h00);
    quiet(0, 40);
    bus_wr(`UBRG_OFF_MODE, 8'hFF);
    bus_rd(`UBRG_OFF_MODE, 8'hE0);
    bus_rd(`UBRG_OFF_STATUS, 8'hE4);
    quiet(2, 30);
    for (int i = 0; i <= 10; i++) begin
      bus_wr(`UBRG_OFF_CKSEL, i[7:0]);
      gap(0, n);
      gap(0, n);
      chk(n, 1 << i);
    end
    bus_wr(`UBRG_OFF_CKSEL, 8'h0B);
    quiet(0, 20);
    @(posedge clk) tmr <= 1'b1;
    gap(0, n);
    chk(n < 8, 1);
    quiet(0, 20);
    bus_wr(`UBRG_OFF_CKSEL, 8'h00);
    for (int j = 0; j < 3; j++) begin
      k = j == 0 ? 4 : (j == 1 ? 255 : 4 + $urandom % 252);
      bus_wr(`UBRG_OFF_DIV, k[7:0]);
      bus_wr(8'h14, 8'h09);
      bus_rd(`UBRG_OFF_DIV, k[7:0]);
      d = 8'($urandom);
      bus_wr(`UBRG_OFF_TXBUF, d);
      #1;
      chk(tload, 1);
      chk(tdat, d);
      gap(1, n);
      chk(n, k);
      gap(1, n);
      chk(n, k);
      pulse(3'b001, 1'b1);
      gap(1, n);
      chk(n, k);
      pulse(3'b001, 1'b0);
      gap(1, n);
      chk(n, k - 2);
      @(posedge clk) busy <= 1'b1;
      bus_wr(`UBRG_OFF_TXBUF, d);
      gap(1, n);
      chk(n, k - 3);
      @(posedge clk) busy <= 1'b0;
    end
    k = 5;
    bus_wr(`UBRG_OFF_DIV, 8'h05);
    bus_wr(`UBRG_OFF_CKSEL, 8'h02);
    gap(1, n);
    gap(1, n);
    chk(n, 4 * k);
    bus_wr(`UBRG_OFF_CKSEL, 8'h00);
    bus_wr(`UBRG_OFF_MODE, 8'hA0);
    #1;
    chk(trun, 0);
    quiet(1, 300);
    pulse(3'b010, 1'b0);
    gap(2, n);
    chk(n, k);
    gap(2, n);
    chk(n, k);
    pulse(3'b100, 1'b0);
    #1;
    chk(rrun, 0);
    quiet(2, 3 * k);
    bus_wr(`UBRG_OFF_MODE, 8'h80);
    pulse(3'b010, 1'b0);
    quiet(2, 30);
    final_report();
  end
endmodule
